// file: rtl/probe_responder.sv
`timescale 1ns/100ps
// Behaviour
// - System requests bus before driving commands
// - Hold two commands; system never sends third
// - Bus owner drives 0000 when idle
// - Invalidate: L2 hit acks, invalidates; else no_acknowledge_reply
// - Invalidate miss with board: board ack, invalidate
// - Mark shared: L2 shared bit, board shared-clean
// - Mark shared reply: L2, board, else no_acknowledge_reply
// - Read modified: dirty L2 hit returns data
// - Read modified miss with board: board ack
// - Read and remove invalidates instead of sharing
// - Response bit 2 is L2 or lock hit
// - Reply delay is the board minimum when board present, else L2 ack or no_acknowledge_reply minimum, sysclk rounded
// - L2 data starts with response edge
// - Board data write follows each L2-sourced chunk; board tag is written once
// - Board indexed at response, advanced per acknowledge
// - Board tag written during second chunk
// - Invalidate never returns data
// - Release drivers on edge request seen
module probe_responder #(
    parameter logic [probe_pkg::REPLY_W-1:0] REPLY_NO_ACKNOWLEDGE_REPLY = probe_pkg::REPLY_NO_ACKNOWLEDGE_REPLY_DEF,
    parameter logic [probe_pkg::REPLY_W-1:0] REPLY_L2    = probe_pkg::REPLY_L2_DEF,
    parameter logic [probe_pkg::REPLY_W-1:0] REPLY_BOARD = probe_pkg::REPLY_BOARD_DEF
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    // Link
    probe_link_if.device                      link,
    // Configuration
    input  wire logic                         board_present_i,
    // Cache probe
    output logic                              probe_req_o,
    output logic [probe_pkg::ADDR_W-1:0]      probe_addr_o,
    input  wire logic                         l2_hit_i,
    input  wire logic                         l2_dirty_i,
    input  wire logic                         lock_hit_i,
    // Block data source
    output logic [probe_pkg::CHUNK_W-1:0]     chunk_o,
    output logic                              board_read_o,
    input  wire logic [probe_pkg::DATA_W-1:0] chunk_data_i,
    // State updates
    output logic                              l2_inval_o,
    output logic                              l2_mark_shared_o,
    output logic                              board_tag_we_o,
    output logic [probe_pkg::TAG_W-1:0]       board_tag_state_o,
    output logic                              board_data_we_o
);
    import probe_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_LOOK, S_WAIT, S_XFER} state_e;

    localparam logic [3:0] NO_ACKNOWLEDGE_REPLY_D = 4'(NO_ACKNOWLEDGE_REPLY_CYC);
    localparam logic [3:0] L2_D    = 4'(L2_ACK_CYC);
    localparam logic [3:0] BOARD_D = 4'(BOARD_CYC);

    state_e              state_r;
    logic [CMD_W-1:0]    q_cmd  [QUEUE_DEPTH];
    logic [ADDR_W-1:0]   q_addr [QUEUE_DEPTH];
    logic                wr_ptr_r;
    logic                rd_ptr_r;
    logic [1:0]          q_cnt_r;
    logic                own_r;
    logic [CMD_W-1:0]    cur_cmd_r;
    logic                hit_r;
    logic                dirty_r;
    logic                lock_r;
    logic                board_r;
    logic [3:0]          cnt_r;
    logic                from_l2_r;
    logic                tag_done_r;
    logic [RES_W-1:0]    res_r;
    logic                res_valid_r;
    logic [DATA_W-1:0]   data_r;
    logic                data_valid_r;

    // Command capture only once our drivers are off and the queue has room
    wire capture_w = ~own_r & link.addr_bus_req & (link.cmd != CMD_NOP)
                     & (q_cnt_r != 2'(QUEUE_DEPTH));
    wire pop_w     = (state_r == S_IDLE) & (q_cnt_r != 2'h0);

    // Reply decode from the latched probe result
    wire is_rd_w     = (cur_cmd_r == CMD_READ_MOD) | (cur_cmd_r == CMD_READ_REMOVE);
    wire is_remove_w = (cur_cmd_r == CMD_READ_REMOVE);
    wire is_inval_w  = (cur_cmd_r == CMD_INVALIDATE);
    wire l2_data_w   = is_rd_w & hit_r & dirty_r;
    wire l2_ack_w    = is_rd_w ? l2_data_w : hit_r;
    wire [REPLY_W-1:0] reply_w = l2_ack_w ? REPLY_L2 :
                                 board_r  ? REPLY_BOARD : REPLY_NO_ACKNOWLEDGE_REPLY;
    wire [3:0] delay_w = board_r ? BOARD_D : (l2_ack_w ? L2_D : NO_ACKNOWLEDGE_REPLY_D);
    wire respond_w  = (state_r == S_WAIT) & ((cnt_r + 4'h1) >= delay_w);
    wire moves_w    = is_rd_w & (l2_ack_w | board_r);
    wire last_ack_w = link.dack & data_valid_r & (chunk_o == 2'(CHUNKS - 1));

    // Two-entry command queue
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            q_cnt_r  <= 2'h0;
            own_r    <= 1'b1;
        end
        else
        begin
            own_r    <= ~link.addr_bus_req;
            wr_ptr_r <= wr_ptr_r ^ capture_w;
            rd_ptr_r <= rd_ptr_r ^ pop_w;
            q_cnt_r  <= q_cnt_r + 2'(capture_w) - 2'(pop_w);
        end
    end

    // Queue storage has no reset; entries are read only when counted
    always_ff @(posedge clk_i)
    begin
        if (capture_w)
        begin
            q_cmd[wr_ptr_r]  <= link.cmd;
            q_addr[wr_ptr_r] <= link.addr;
        end
    end

    // Probe sequencer
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r           <= S_IDLE;
            cur_cmd_r         <= CMD_NOP;
            probe_addr_o      <= '0;
            probe_req_o       <= 1'b0;
            {hit_r, dirty_r, lock_r, board_r} <= 4'h0;
            cnt_r             <= 4'h0;
            from_l2_r         <= 1'b0;
            tag_done_r        <= 1'b0;
            chunk_o           <= '0;
            board_read_o      <= 1'b0;
            res_r             <= '0;
            res_valid_r       <= 1'b0;
            data_r            <= '0;
            data_valid_r      <= 1'b0;
            l2_inval_o        <= 1'b0;
            l2_mark_shared_o  <= 1'b0;
            board_tag_we_o    <= 1'b0;
            board_tag_state_o <= TAG_INVALID;
            board_data_we_o   <= 1'b0;
        end
        else
        begin
            probe_req_o      <= 1'b0;
            res_valid_r      <= 1'b0;
            l2_inval_o       <= 1'b0;
            l2_mark_shared_o <= 1'b0;
            board_tag_we_o   <= 1'b0;
            board_data_we_o  <= 1'b0;
            cnt_r            <= cnt_r + 4'h1;
            case (state_r)
                S_IDLE:
                begin
                    if (pop_w)
                    begin
                        cur_cmd_r    <= q_cmd[rd_ptr_r];
                        probe_addr_o <= q_addr[rd_ptr_r];
                        probe_req_o  <= 1'b1;
                        chunk_o      <= '0;
                        cnt_r        <= 4'h0;
                        state_r      <= S_LOOK;
                    end
                end
                S_LOOK:
                begin
                    // Probe results are sampled in the same cycle that probe_req_o is high
                    hit_r   <= l2_hit_i;
                    dirty_r <= l2_dirty_i;
                    lock_r  <= lock_hit_i;
                    board_r <= board_present_i;
                    state_r <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (respond_w)
                    begin
                        res_r       <= {hit_r | lock_r, reply_w};
                        res_valid_r <= 1'b1;
                        // Present copy: invalidate or mark shared
                        l2_inval_o       <= hit_r & (is_inval_w | is_remove_w);
                        l2_mark_shared_o <= hit_r & ~is_inval_w & ~is_remove_w;
                        // Non-data board tag writes happen with the reply
                        board_tag_we_o    <= board_r & ~is_rd_w;
                        board_tag_state_o <= is_inval_w ? TAG_INVALID : TAG_SHARED_CLEAN;
                        from_l2_r    <= l2_data_w;
                        tag_done_r   <= 1'b0;
                        board_read_o <= moves_w & ~l2_data_w;
                        data_valid_r <= l2_data_w;
                        if (l2_data_w)
                            data_r <= chunk_data_i;
                        state_r <= moves_w ? S_XFER : S_IDLE;
                    end
                end
                S_XFER:
                begin
                    if (!data_valid_r)
                    begin
                        // Load the chunk selected by the current index
                        data_r       <= chunk_data_i;
                        data_valid_r <= 1'b1;
                        if ((chunk_o == 2'h1) & board_r & ~tag_done_r)
                        begin
                            board_tag_we_o    <= 1'b1;
                            board_tag_state_o <= is_remove_w ? TAG_INVALID
                                                             : TAG_SHARED_DIRTY;
                            tag_done_r        <= 1'b1;
                        end
                    end
                    else if (link.dack)
                    begin
                        // Chunk handed over; copy into board when sourced on chip
                        board_data_we_o <= from_l2_r & board_r;
                        data_valid_r    <= 1'b0;
                        chunk_o         <= chunk_o + 2'h1;
                        if (last_ack_w)
                        begin
                            board_read_o <= 1'b0;
                            state_r      <= S_IDLE;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Device never originates commands here, so it idles the bus at NOP
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            link.dev_cmd <= CMD_NOP;
        else
            link.dev_cmd <= CMD_NOP;
    end

    assign link.dev_cmd_oe = own_r;
    assign link.res        = res_r;
    assign link.res_valid  = res_valid_r;
    assign link.data       = data_r;
    assign link.data_valid = data_valid_r;
endmodule

// file: rtl/probe_pkg.sv
package probe_pkg;
    // Link field widths
    localparam int CMD_W       = 4;
    localparam int ADDR_W      = 36;
    localparam int DATA_W      = 128;
    localparam int RES_W       = 3;
    localparam int REPLY_W     = 2;
    localparam int CHUNK_W     = 2;
    localparam int CHUNKS      = 4;
    localparam int QUEUE_DEPTH = 2;
    localparam int TAG_W       = 3;

    // System command codes
    localparam logic [CMD_W-1:0] CMD_NOP         = 4'h0;
    localparam logic [CMD_W-1:0] CMD_INVALIDATE  = 4'h2;
    localparam logic [CMD_W-1:0] CMD_MARK_SHARED = 4'h3;
    localparam logic [CMD_W-1:0] CMD_READ_MOD    = 4'h5;
    localparam logic [CMD_W-1:0] CMD_READ_REMOVE = 4'h7;

    // Default reply codes on response bits 1:0
    localparam logic [REPLY_W-1:0] REPLY_NO_ACKNOWLEDGE_REPLY_DEF = 2'h0;
    localparam logic [REPLY_W-1:0] REPLY_L2_DEF    = 2'h1;
    localparam logic [REPLY_W-1:0] REPLY_BOARD_DEF = 2'h2;

    // Board tag state {valid, shared, dirty}
    localparam logic [TAG_W-1:0] TAG_INVALID       = 3'h0;
    localparam logic [TAG_W-1:0] TAG_SHARED_CLEAN  = 3'h6;
    localparam logic [TAG_W-1:0] TAG_SHARED_DIRTY  = 3'h7;

    // Timing: system clock and assumed processor clock
    localparam int SYSCLK_NS       = 50;
    localparam int CPU_NS          = 10;
    localparam int MIN_NO_ACKNOWLEDGE_REPLY_CPU   = 8;
    localparam int MIN_L2_ACK_CPU  = 12;
    localparam int MIN_BOARD_CPU   = 10;
    localparam int NO_ACKNOWLEDGE_REPLY_CYC  = (MIN_NO_ACKNOWLEDGE_REPLY_CPU * CPU_NS + SYSCLK_NS - 1) / SYSCLK_NS;
    localparam int L2_ACK_CYC = (MIN_L2_ACK_CPU * CPU_NS + SYSCLK_NS - 1) / SYSCLK_NS;
    localparam int BOARD_CYC  = (MIN_BOARD_CPU * CPU_NS + SYSCLK_NS - 1) / SYSCLK_NS;
endpackage

// file: rtl/probe_link_if.sv
`timescale 1ns/100ps
interface probe_link_if;
    import probe_pkg::*;
    logic                addr_bus_req;
    logic [CMD_W-1:0]    sys_cmd;
    logic                sys_cmd_oe;
    logic [ADDR_W-1:0]   sys_addr;
    logic [CMD_W-1:0]    dev_cmd;
    logic                dev_cmd_oe;
    logic [CMD_W-1:0]    cmd;
    logic [ADDR_W-1:0]   addr;
    logic [RES_W-1:0]    res;
    logic                res_valid;
    logic [DATA_W-1:0]   data;
    logic                data_valid;
    logic                dack;

    // Shared command/address wire level from the two enables
    assign cmd  = sys_cmd_oe ? sys_cmd : (dev_cmd_oe ? dev_cmd : CMD_NOP);
    assign addr = sys_cmd_oe ? sys_addr : '0;

    modport device (
        input  addr_bus_req, cmd, addr, dack,
        output dev_cmd, dev_cmd_oe, res, res_valid, data, data_valid
    );
    modport system (
        input  cmd, res, res_valid, data, data_valid,
        output addr_bus_req, sys_cmd, sys_cmd_oe, sys_addr, dack
    );
endinterface

// file: rtl/probe_system_end.sv
`timescale 1ns/100ps
module probe_system_end (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        reset_i,
    // Link
    probe_link_if.system                     link,
    // Command request
    input  wire logic                        send_i,
    input  wire logic [probe_pkg::CMD_W-1:0]  send_cmd_i,
    input  wire logic [probe_pkg::ADDR_W-1:0] send_addr_i,
    output logic                             send_ready_o,
    // Replies and data
    output logic [probe_pkg::RES_W-1:0]      reply_o,
    output logic                             reply_valid_o,
    output logic [probe_pkg::DATA_W-1:0]     chunk_o,
    output logic                             chunk_valid_o
);
    import probe_pkg::*;

    typedef enum logic [1:0] {B_IDLE, B_REQ, B_TURN, B_DRIVE} bus_state_e;

    bus_state_e          state_r;
    bus_state_e          state_nxt;
    logic [1:0]          pend_r;
    logic [1:0]          pend_nxt;
    logic [CMD_W-1:0]    cmd_r;
    logic [ADDR_W-1:0]   addr_r;
    logic                req_r;
    logic                oe_r;
    logic                dack_r;
    wire                 accept_w = send_i & send_ready_o;

    // Outstanding count: sent minus answered, never above two
    assign pend_nxt = pend_r + 2'(accept_w) - 2'(link.res_valid);

    // Ownership sequence: request, turnaround, drive one cycle, release
    always_comb
    begin
        case (state_r)
            B_IDLE:  state_nxt = accept_w ? B_REQ : B_IDLE;
            B_REQ:   state_nxt = B_TURN;   // Device drops its drivers here
            B_TURN:  state_nxt = B_DRIVE;
            B_DRIVE: state_nxt = B_IDLE;
            default: state_nxt = B_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r      <= B_IDLE;
            pend_r       <= 2'h0;
            cmd_r        <= CMD_NOP;
            addr_r       <= '0;
            req_r        <= 1'b0;
            oe_r         <= 1'b0;
            send_ready_o <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            pend_r       <= pend_nxt;
            req_r        <= (state_nxt != B_IDLE);
            oe_r         <= (state_nxt == B_DRIVE);
            // Hold the command through request and turnaround; NOP once idle
            cmd_r        <= (state_nxt == B_IDLE) ? CMD_NOP : cmd_r;
            send_ready_o <= (state_nxt == B_IDLE) & (pend_nxt < 2'(QUEUE_DEPTH));
            if (accept_w)
            begin
                cmd_r  <= send_cmd_i;
                addr_r <= send_addr_i;
            end
        end
    end

    // One acknowledge per presented chunk paces the device
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            dack_r        <= 1'b0;
            chunk_o       <= '0;
            chunk_valid_o <= 1'b0;
            reply_o       <= '0;
            reply_valid_o <= 1'b0;
        end
        else
        begin
            dack_r        <= link.data_valid & ~dack_r;
            chunk_valid_o <= link.data_valid & ~dack_r;
            if (link.data_valid & ~dack_r)
                chunk_o <= link.data;
            reply_valid_o <= link.res_valid;
            if (link.res_valid)
                reply_o <= link.res;
        end
    end

    assign link.addr_bus_req = req_r;
    assign link.sys_cmd_oe   = oe_r;
    assign link.sys_cmd      = cmd_r;
    assign link.sys_addr     = addr_r;
    assign link.dack         = dack_r;
endmodule

// file: dv/probe_link_properties.sv
`timescale 1ns/100ps
module probe_link_properties
    import probe_pkg::*;
(
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              reset_i,
    // Command/address bus
    input wire logic              addr_bus_req,
    input wire logic              sys_cmd_oe,
    input wire logic              dev_cmd_oe,
    input wire logic [CMD_W-1:0]  cmd,
    // Reply and data
    input wire logic [RES_W-1:0]  res,
    input wire logic              res_valid,
    input wire logic [DATA_W-1:0] data,
    input wire logic              data_valid,
    input wire logic              dack
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // Reply kinds and chunk hand-over steps
    sequence s_board_reply;
        res_valid && res[1:0] == REPLY_BOARD_DEF;
    endsequence
    sequence s_no_acknowledge_reply_reply;
        res_valid && res[1:0] == REPLY_NO_ACKNOWLEDGE_REPLY_DEF;
    endsequence
    sequence s_chunk_take;
        data_valid && dack;
    endsequence

    // Bus ownership; a clash here would short the shared lines
    a_release_on_req: assert property (addr_bus_req |=> !dev_cmd_oe)
        else $error("device kept driving after bus request");
    a_no_drive_clash: assert property (!(sys_cmd_oe && dev_cmd_oe))
        else $error("both ends drive the command bus");
    a_req_before_cmd: assert property (sys_cmd_oe |-> addr_bus_req && $past(addr_bus_req))
        else $error("system drove a command without owning the bus");
    a_idle_is_nop: assert property (!sys_cmd_oe |-> cmd == CMD_NOP)
        else $error("idle command bus not at no-operation");
    // Data timing relative to the reply
    a_l2_data_reply: assert property (res_valid && data_valid
        |-> res[1:0] == REPLY_L2_DEF)
        else $error("data at reply edge without on-chip acknowledge");
    a_board_data_lag: assert property (s_board_reply |-> !data_valid)
        else $error("board data present at the indexing edge");
    a_no_acknowledge_reply_no_data: assert property (s_no_acknowledge_reply_reply |-> !data_valid [*2])
        else $error("data returned with no-acknowledge");
    // Next chunk loads one edge after the take, so the take is two samples back
    a_chunk_cause: assert property ($rose(data_valid) |-> res_valid || $past(res_valid)
        || $past(dack, 2))
        else $error("chunk appeared without reply or acknowledge");
    a_take_advance: assert property (s_chunk_take |=> !data_valid && !dack)
        else $error("chunk not advanced after take or acknowledge not spaced");
    a_data_stands: assert property (data_valid && !dack |=> data_valid && $stable(data))
        else $error("chunk dropped before it was taken");
endmodule

// file: dv/coherence_probe_responder_tb.sv
`timescale 1ns/100ps
module coherence_probe_responder_tb;
    import probe_pkg::*;
    // Bench signals
    logic               clk_i;
    logic               reset_i;
    logic               send_i;
    logic [CMD_W-1:0]   send_cmd_i;
    logic [ADDR_W-1:0]  send_addr_i;
    logic               send_ready;
    logic [RES_W-1:0]   reply;
    logic               reply_valid;
    logic [DATA_W-1:0]  sys_chunk;
    logic               sys_chunk_valid;
    logic               board_i;
    logic               l2_hit;
    logic               l2_dirty;
    logic               lock_hit;
    logic               probe_req;
    logic [ADDR_W-1:0]  probe_addr;
    logic [CHUNK_W-1:0] rsp_chunk;
    logic               board_read;
    logic               l2_inval;
    logic               l2_mark;
    logic               tag_we;
    logic               data_we;
    logic [TAG_W-1:0]   tag_state;
    logic [DATA_W-1:0]  chunk_data;
    int                 fail_count;
    int                 comparisons;
    int                 n_rv;
    int                 n_ch;
    int                 n_inv;
    int                 n_ms;
    int                 n_tw;
    int                 n_dw;
    int                 n_pr;
    logic [RES_W-1:0]   got_res;
    logic [TAG_W-1:0]   got_tag;
    logic [DATA_W-1:0]  got [4];

    probe_link_if link_if ();
    probe_system_end probe_system_end_inst (.clk_i(clk_i), .reset_i(reset_i),
        .link(link_if.system), .send_i(send_i), .send_cmd_i(send_cmd_i),
        .send_addr_i(send_addr_i), .send_ready_o(send_ready), .reply_o(reply),
        .reply_valid_o(reply_valid), .chunk_o(sys_chunk), .chunk_valid_o(sys_chunk_valid));
    probe_responder probe_responder_inst (.clk_i(clk_i), .reset_i(reset_i),
        .link(link_if.device), .board_present_i(board_i), .probe_req_o(probe_req),
        .probe_addr_o(probe_addr), .l2_hit_i(l2_hit), .l2_dirty_i(l2_dirty),
        .lock_hit_i(lock_hit), .chunk_o(rsp_chunk), .board_read_o(board_read),
        .chunk_data_i(chunk_data), .l2_inval_o(l2_inval), .l2_mark_shared_o(l2_mark),
        .board_tag_we_o(tag_we), .board_tag_state_o(tag_state), .board_data_we_o(data_we));
    probe_link_properties probe_link_properties_inst (.clk_i(clk_i), .reset_i(reset_i),
        .addr_bus_req(link_if.addr_bus_req), .sys_cmd_oe(link_if.sys_cmd_oe),
        .dev_cmd_oe(link_if.dev_cmd_oe), .cmd(link_if.cmd), .res(link_if.res),
        .res_valid(link_if.res_valid), .data(link_if.data),
        .data_valid(link_if.data_valid), .dack(link_if.dack));

    // Block store: source is visible in the inverted pattern
    assign chunk_data = {4{probe_addr[29:0], rsp_chunk}} ^ {DATA_W{board_read}};

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Tally activity; reads land before this edge's own updates
    always @(posedge clk_i)
    begin
        if (reply_valid === 1'b1)
        begin
            n_rv <= n_rv + 1;
            got_res <= reply;
        end
        if (sys_chunk_valid === 1'b1)
        begin
            got[n_ch[1:0]] <= sys_chunk;
            n_ch <= n_ch + 1;
        end
        if (tag_we === 1'b1)
        begin
            n_tw <= n_tw + 1;
            got_tag <= tag_state;
        end
        n_inv <= n_inv + int'(l2_inval === 1'b1);
        n_ms <= n_ms + int'(l2_mark === 1'b1);
        n_dw <= n_dw + int'(data_we === 1'b1);
        n_pr <= n_pr + int'(probe_req === 1'b1);
    end

    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One command, one cycle of send request once the end is ready
    task automatic send(input logic [CMD_W-1:0] c, input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        while (send_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk_i);
            n++;
        end
        chk(DATA_W'(send_ready === 1'b1), DATA_W'(1));
        send_cmd_i = c;
        send_addr_i = a;
        send_i = 1'b1;
        @(negedge clk_i);
        send_i = 1'b0;
    endtask

    // cfg = {board, l2 hit, l2 dirty, lock hit}; src 1 = board data
    task automatic run(input logic [CMD_W-1:0] c, input logic [3:0] cfg,
        input logic [RES_W-1:0] er, input int nd, input logic src, input int tw,
        input logic [TAG_W-1:0] ts, input int iv, input int ms);
        int lat;
        int mn;
        logic [ADDR_W-1:0] a;
        a = {32'h1234_5670, c};
        {board_i, l2_hit, l2_dirty, lock_hit} = cfg;
        {n_rv, n_ch, n_inv, n_ms, n_tw, n_dw, n_pr} = '0;
        send(c, a);
        lat = 1;
        while (n_rv == 0 && lat < 60)
        begin
            @(negedge clk_i);
            lat++;
        end
        mn = (er[1:0] === REPLY_NO_ACKNOWLEDGE_REPLY_DEF) ? NO_ACKNOWLEDGE_REPLY_CYC : L2_ACK_CYC;
        mn = cfg[3] ? BOARD_CYC : mn;
        // Seven cycles of handover and return path surround the probe delay
        chk(DATA_W'(lat >= 7 + mn), DATA_W'(1));
        if (c === CMD_INVALIDATE)
            chk(DATA_W'(got_res[1:0]), DATA_W'(er[1:0]));
        else
            chk(DATA_W'(got_res), DATA_W'(er));
        while (n_ch < nd && lat < 120)
        begin
            @(negedge clk_i);
            lat++;
        end
        // Trailing update pulses may land after the last chunk
        repeat (4) @(negedge clk_i);
        chk(DATA_W'(n_rv), DATA_W'(1));
        chk(DATA_W'(n_pr), DATA_W'(1));
        chk(DATA_W'(probe_addr), DATA_W'(a));
        chk(DATA_W'(n_ch), DATA_W'(nd));
        for (int i = 0; i < nd; i++)
            chk(got[i], {4{a[29:0], 2'(i)}} ^ {DATA_W{src}});
        chk(DATA_W'(n_tw), DATA_W'(tw));
        if (tw > 0)
            chk(DATA_W'(got_tag), DATA_W'(ts));
        chk(DATA_W'(n_inv), DATA_W'(iv));
        chk(DATA_W'(n_ms), DATA_W'(ms));
        if (!src && cfg[3] && nd == 4)
            chk(DATA_W'(n_dw), DATA_W'(4));
    endtask

    task automatic t_invalidate();
        run(CMD_INVALIDATE, 4'h4, {1'b1, REPLY_L2_DEF}, 0, 0, 0, TAG_INVALID, 1, 0);
        run(CMD_INVALIDATE, 4'h0, {1'b0, REPLY_NO_ACKNOWLEDGE_REPLY_DEF}, 0, 0, 0, TAG_INVALID, 0, 0);
        run(CMD_INVALIDATE, 4'h8, {1'b0, REPLY_BOARD_DEF}, 0, 0, 1, TAG_INVALID, 0, 0);
        $display("test invalidate done");
    endtask

    task automatic t_mark_shared();
        run(CMD_MARK_SHARED, 4'h4, {1'b1, REPLY_L2_DEF}, 0, 0, 0, TAG_INVALID, 0, 1);
        run(CMD_MARK_SHARED, 4'h9, {1'b1, REPLY_BOARD_DEF}, 0, 0, 1, TAG_SHARED_CLEAN, 0, 0);
        run(CMD_MARK_SHARED, 4'h0, {1'b0, REPLY_NO_ACKNOWLEDGE_REPLY_DEF}, 0, 0, 0, TAG_INVALID, 0, 0);
        $display("test mark shared done");
    endtask

    task automatic t_read_mod();
        run(CMD_READ_MOD, 4'h6, {1'b1, REPLY_L2_DEF}, 4, 0, 0, TAG_INVALID, 0, 1);
        run(CMD_READ_MOD, 4'h4, {1'b1, REPLY_NO_ACKNOWLEDGE_REPLY_DEF}, 0, 0, 0, TAG_INVALID, 0, 1);
        run(CMD_READ_MOD, 4'h8, {1'b0, REPLY_BOARD_DEF}, 4, 1, 1, TAG_SHARED_DIRTY, 0, 0);
        $display("test read modified done");
    endtask

    task automatic t_read_remove();
        run(CMD_READ_REMOVE, 4'hE, {1'b1, REPLY_L2_DEF}, 4, 0, 1, TAG_INVALID, 1, 0);
        run(CMD_READ_REMOVE, 4'h9, {1'b1, REPLY_BOARD_DEF}, 4, 1, 1, TAG_INVALID, 0, 0);
        $display("test read remove done");
    endtask

    // Three long data commands: two wait in the queue while the first moves data
    task automatic t_two_queued();
        int n;
        {board_i, l2_hit, l2_dirty, lock_hit} = 4'hE;
        {n_rv, n_inv, n_ch} = '0;
        send(CMD_READ_REMOVE, 36'h0_0000_1000);
        send(CMD_READ_REMOVE, 36'h0_0000_2000);
        send(CMD_READ_REMOVE, 36'h0_0000_3000);
        n = 0;
        while ((n_rv < 3 || n_ch < 12) && n < 200)
        begin
            @(negedge clk_i);
            n++;
        end
        repeat (4) @(negedge clk_i);
        chk(DATA_W'(n_rv), DATA_W'(3));
        chk(DATA_W'(n_inv), DATA_W'(3));
        chk(DATA_W'(n_ch), DATA_W'(12));
        $display("test two queued done");
    endtask

    initial
    begin
        reset_i = 1'b1;
        send_i = 1'b0;
        send_cmd_i = CMD_NOP;
        send_addr_i = '0;
        {board_i, l2_hit, l2_dirty, lock_hit} = 4'h0;
        {fail_count, comparisons, n_rv, n_ch, n_inv, n_ms, n_tw, n_dw} = '0;
        repeat (2) @(negedge clk_i);
        reset_i = 1'b0;
        t_invalidate();
        t_mark_shared();
        t_read_mod();
        t_read_remove();
        t_two_queued();
        results();
    end

    // Whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        results();
    end
endmodule
